// file: rrwdr_top.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Pin low 200 us always resets device
// R2: All resets synchronized to system clock
// R3: Reset switches clock to medium RC oscillator
// R4: Reset loads option start address, SFR defaults
// R5: Reset clears stack pointer to zero
// R6: Reset never touches data RAM
// R7: Pin reaching high means runaway: reset/interrupt
// R8: Discharge stretched 1920 to 2048 cycles
// R9: Runaway flag set on reset-runaway, software clears
// R10: Bit 5 is plain general-purpose flag
// R11: Standby with stop bit clears run bits
// R12: Standby without stop bit changes nothing
// R13: Clear while running discharges and stretches
// R14: Clear-enable low blocks discharge and clear
// R15: Clear-enable set while stopped still discharges
// R16: Reset-select picks reset or interrupt zero
// R17: Run starts on 1, stops only on reset or standby with stop bit
// R18: Reset-select resets even when not running
// R19: Running watchdog ignores ordinary control writes
// R20: Software clears running watchdog writing 55h
// R21: Pin, POR/LOW_VOLTAGE_RESET, timer-watchdog reset clear control
// R22: Software discharges with 04h before starting
// R23: Pin detection synchronized before use
module rrwdr_top #(
	parameter logic [15:0] START_ADDR_A = 16'h0000,
	parameter logic [15:0] START_ADDR_B = 16'h0000,
	parameter int unsigned TCYC_DIV = 1
)(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [17:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic external_reset_pin_n, // Reset pin
	input wire logic por_lvd_reset, // Analog reset request
	input wire logic itimer_wdt_reset, // Timer-watchdog reset
	input wire logic standby_enter, // HALT/HOLD entry pulse
	input wire logic start_opt_sel, // Start address option
	input wire logic watchdog_rc_pin_i, // High-threshold input
	output logic watchdog_rc_pin_o, // Pin drive level
	output logic watchdog_rc_pin_oe, // Discharge transistor on
	output logic core_reset, // Synchronous core reset
	output logic clk_sel_medium_rc, // Medium RC clock chosen
	output logic pc_load, // Program counter load
	output logic [15:0] pc_load_addr, // Start address
	output logic [15:0] sp_init, // Stack pointer value
	output logic ext_interrupt_zero, // Interrupt zero pulse
	output logic [15:0] ext_interrupt_zero_vector // Interrupt zero vector
);

	initial
	begin
		if (TCYC_DIV < 1 || TCYC_DIV > 65536)
		begin
			$error("TCYC_DIV must be 1 to 65536");
		end
	end

	// Pin synchronizers: 0 rc pin high, 1 reset pin low, 2 POR/LOW_VOLTAGE_RESET
	logic [2:0] async_in;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic [2:0] stable_r;
	logic pin_hi;
	logic pin_hi_d_r;
	logic pin_low;
	logic por_req;

	assign async_in = {por_lvd_reset, ~external_reset_pin_n, watchdog_rc_pin_i};

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
		end
		else
		begin
			s1_r <= async_in; // see R23
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stable_r <= 3'h0;
			pin_hi_d_r <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (s2_r[i] == s3_r[i])
				begin
					stable_r[i] <= s3_r[i]; // see R23
				end
			end
			pin_hi_d_r <= stable_r[0];
		end
	end

	assign pin_hi = stable_r[0];
	assign pin_low = stable_r[1];
	assign por_req = stable_r[2];

	// Instruction cycle enable
	logic [15:0] div_cnt_r;
	logic tcyc_en;

	assign tcyc_en = (div_cnt_r == 16'(TCYC_DIV - 1));

	always_ff @(posedge clk)
	begin
		if (rst || tcyc_en)
		begin
			div_cnt_r <= 16'h0000;
		end
		else
		begin
			div_cnt_r <= div_cnt_r + 16'h0001;
		end
	end

	// Bus slave: one wait cycle per access
	logic ack_r;
	logic bus_req;
	logic wr_do;
	logic rd_take;
	logic [7:0] wdat;
	logic wr_ctrl;
	logic wr_clks;

	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_r;
	assign wr_do = avs_write & ack_r & avs_byteenable[0];
	assign rd_take = avs_read & ~ack_r;
	assign wdat = avs_writedata[7:0];
	assign wr_ctrl = wr_do && (avs_address == rrwdr_pkg::CTRL_ADDR);
	assign wr_clks = wr_do && (avs_address == rrwdr_pkg::CLKS_ADDR);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= bus_req & ~ack_r;
		end
	end

	// Control register and runaway detection
	logic [7:0] ctrl_r;
	logic run;
	logic full_clr;
	logic fire_rst;
	logic fire_int;
	logic clear_op;
	logic stop_wr;
	logic dis_start;

	assign run = ctrl_r[rrwdr_pkg::RUN_BIT];
	// Pin, POR/LOW_VOLTAGE_RESET and timer-watchdog resets wipe the register
	assign full_clr = rst | pin_low | por_req | itimer_wdt_reset; // see R21
	// Reset case acts on level, even when stopped
	assign fire_rst = pin_hi & ctrl_r[rrwdr_pkg::RST_BIT]; // see R7 R16 R18
	assign fire_int = pin_hi & ~pin_hi_d_r & run & ~ctrl_r[rrwdr_pkg::RST_BIT]; // see R7 R16
	assign clear_op = wr_ctrl & run & ctrl_r[rrwdr_pkg::CLR_BIT] & (wdat == rrwdr_pkg::CLEAR_CODE); // see R13 R14 R20
	assign stop_wr = wr_ctrl & ~run;
	assign dis_start = clear_op | (stop_wr & wdat[rrwdr_pkg::CLR_BIT]); // see R15

	always_ff @(posedge clk)
	begin
		if (full_clr)
		begin
			ctrl_r <= rrwdr_pkg::CTRL_RESET; // see R21
		end
		else if (fire_rst)
		begin
			// Runaway reset stops the watchdog, flag survives
			ctrl_r[rrwdr_pkg::FLAG_BIT] <= 1'b1; // see R9
			ctrl_r[rrwdr_pkg::CLR_BIT] <= 1'b0;
			ctrl_r[rrwdr_pkg::RST_BIT] <= 1'b0;
			ctrl_r[rrwdr_pkg::RUN_BIT] <= 1'b0; // see R17
		end
		else if (standby_enter)
		begin
			if (ctrl_r[rrwdr_pkg::HLT_BIT]) // see R11 R12
			begin
				ctrl_r[rrwdr_pkg::CLR_BIT] <= 1'b0; // see R11
				ctrl_r[rrwdr_pkg::RST_BIT] <= 1'b0;
				ctrl_r[rrwdr_pkg::RUN_BIT] <= 1'b0;
			end
		end
		else if (stop_wr)
		begin
			// Running register is locked; only stopped writes store
			ctrl_r <= (wdat & rrwdr_pkg::CTRL_WMASK) | {ctrl_r[7] & wdat[7], 7'h00}; // see R9 R10 R19
		end
	end

	// Pulse stretcher for the discharge transistor
	logic [rrwdr_pkg::STRETCH_W-1:0] str_cnt_r;
	logic str_active;
	logic dis_on;
	logic halt_stop;

	assign str_active = (str_cnt_r != '0);
	assign halt_stop = standby_enter & ctrl_r[rrwdr_pkg::HLT_BIT];
	assign dis_on = str_active | (~run & ctrl_r[rrwdr_pkg::CLR_BIT]); // see R14 R15

	always_ff @(posedge clk)
	begin
		if (full_clr || fire_rst || halt_stop)
		begin
			str_cnt_r <= '0; // see R11
		end
		else if (dis_start)
		begin
			str_cnt_r <= rrwdr_pkg::STRETCH_W'(rrwdr_pkg::STRETCH_TCYC); // see R8 R13
		end
		else if (str_active && tcyc_en)
		begin
			str_cnt_r <= str_cnt_r - rrwdr_pkg::STRETCH_W'(1); // see R8
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			watchdog_rc_pin_oe <= 1'b0;
		end
		else
		begin
			watchdog_rc_pin_oe <= dis_on & ~full_clr & ~halt_stop; // see R13
		end
	end

	assign watchdog_rc_pin_o = 1'b0;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ext_interrupt_zero <= 1'b0;
		end
		else
		begin
			ext_interrupt_zero <= fire_int; // see R16
		end
	end

	// Core reset sequencer; RAM has no reset path here, see R6
	rrwdr_pkg::rrwdr_rst_state_t rs_r;
	logic [rrwdr_pkg::HOLD_W-1:0] hold_r;
	logic src_any;

	assign src_any = pin_low | por_req | itimer_wdt_reset | fire_rst; // see R1 R2

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rs_r <= rrwdr_pkg::RS_HOLD;
			hold_r <= rrwdr_pkg::HOLD_W'(rrwdr_pkg::HOLD_CYC);
		end
		else
		begin
			case (rs_r)
				rrwdr_pkg::RS_RUN:
				begin
					if (src_any)
					begin
						rs_r <= rrwdr_pkg::RS_HOLD; // see R2
						hold_r <= rrwdr_pkg::HOLD_W'(rrwdr_pkg::HOLD_CYC);
					end
				end
				rrwdr_pkg::RS_HOLD:
				begin
					if (src_any)
					begin
						hold_r <= rrwdr_pkg::HOLD_W'(rrwdr_pkg::HOLD_CYC); // see R1
					end
					else if (hold_r == rrwdr_pkg::HOLD_W'(1))
					begin
						rs_r <= rrwdr_pkg::RS_LOAD;
						hold_r <= '0;
					end
					else
					begin
						hold_r <= hold_r - rrwdr_pkg::HOLD_W'(1);
					end
				end
				rrwdr_pkg::RS_LOAD:
				begin
					rs_r <= src_any ? rrwdr_pkg::RS_HOLD : rrwdr_pkg::RS_RUN;
					hold_r <= rrwdr_pkg::HOLD_W'(rrwdr_pkg::HOLD_CYC);
				end
				default:
				begin
					rs_r <= rrwdr_pkg::RS_HOLD;
					hold_r <= rrwdr_pkg::HOLD_W'(rrwdr_pkg::HOLD_CYC);
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			core_reset <= 1'b1;
			pc_load <= 1'b0;
			pc_load_addr <= 16'h0000;
		end
		else
		begin
			core_reset <= (rs_r != rrwdr_pkg::RS_RUN); // see R2 R4
			pc_load <= (rs_r == rrwdr_pkg::RS_LOAD); // see R4
			if (rs_r == rrwdr_pkg::RS_LOAD)
			begin
				pc_load_addr <= start_opt_sel ? START_ADDR_B : START_ADDR_A; // see R4 R16
			end
		end
	end

	// Clock source select: medium RC on every reset
	always_ff @(posedge clk)
	begin
		if (rst || rs_r != rrwdr_pkg::RS_RUN)
		begin
			clk_sel_medium_rc <= rrwdr_pkg::CLK_MRC_RESET; // see R3
		end
		else if (wr_clks)
		begin
			clk_sel_medium_rc <= ~wdat[0];
		end
	end

	assign sp_init = rrwdr_pkg::SP_RESET; // see R5
	assign ext_interrupt_zero_vector = rrwdr_pkg::EXT_INTERRUPT_ZERO_VECTOR; // see R16

	// Read data, registered at the first cycle of a read
	logic [31:0] rd_val;

	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (avs_address == rrwdr_pkg::CTRL_ADDR)
		begin
			rd_val[7:0] = ctrl_r;
		end
		else if (avs_address == rrwdr_pkg::STAT_ADDR)
		begin
			rd_val[rrwdr_pkg::ST_PIN_BIT] = pin_hi;
			rd_val[rrwdr_pkg::ST_DIS_BIT] = watchdog_rc_pin_oe;
			rd_val[rrwdr_pkg::ST_RUN_BIT] = run;
			rd_val[rrwdr_pkg::ST_MRC_BIT] = clk_sel_medium_rc;
		end
		else if (avs_address == rrwdr_pkg::CLKS_ADDR)
		begin
			rd_val[0] = ~clk_sel_medium_rc;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			avs_readdata <= 32'h0000_0000;
		end
		else if (rd_take)
		begin
			avs_readdata <= rd_val;
		end
	end

endmodule

// file: rrwdr_pkg.sv
package rrwdr_pkg;
	// Register map, byte addresses on the bus
	localparam int unsigned ADDR_W = 18;
	localparam logic [15:0] CTRL_IDX = 16'hfe0f;
	localparam logic [17:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
	localparam logic [17:0] STAT_ADDR = 18'h3f840;
	localparam logic [17:0] CLKS_ADDR = 18'h3f844;

	// Control register fields
	localparam int unsigned FLAG_BIT = 7;
	localparam int unsigned SPARE_BIT = 5;
	localparam int unsigned HLT_BIT = 4;
	localparam int unsigned CLR_BIT = 2;
	localparam int unsigned RST_BIT = 1;
	localparam int unsigned RUN_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h37;
	localparam logic [7:0] CLEAR_CODE = 8'h55;

	// Status register fields
	localparam int unsigned ST_PIN_BIT = 0;
	localparam int unsigned ST_DIS_BIT = 1;
	localparam int unsigned ST_RUN_BIT = 2;
	localparam int unsigned ST_MRC_BIT = 3;

	// Discharge stretch, in instruction cycles
	localparam int unsigned STRETCH_MIN_TCYC = 1920;
	localparam int unsigned STRETCH_MAX_TCYC = 2048;
	localparam int unsigned STRETCH_TCYC = (STRETCH_MIN_TCYC + STRETCH_MAX_TCYC) / 2;
	localparam int unsigned STRETCH_W = 11;

	// Core reset hold after the last source goes away
	localparam int unsigned HOLD_CYC = 16;
	localparam int unsigned HOLD_W = 5;

	localparam logic [15:0] EXT_INTERRUPT_ZERO_VECTOR = 16'h0003;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic CLK_MRC_RESET = 1'b1;

	typedef enum logic [1:0]
	{
		RS_RUN = 2'b00,
		RS_HOLD = 2'b01,
		RS_LOAD = 2'b11
	} rrwdr_rst_state_t;
endpackage

// file: rrwdr_chk.sv
`timescale 1ns/1ps
module rrwdr_chk (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic avs_waitrequest, // stall
	input wire logic standby_enter, // standby
	input wire logic watchdog_rc_pin_o, // pin level
	input wire logic watchdog_rc_pin_oe, // discharge
	input wire logic core_reset, // core reset
	input wire logic clk_sel_medium_rc, // RC clock
	input wire logic pc_load, // PC load
	input wire logic ext_interrupt_zero, // interrupt
	input wire logic [15:0] sp_init, // stack
	input wire logic [15:0] ext_interrupt_zero_vector // vector
);
	logic [15:0] on_r;
	logic kill_r;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Discharge length, and whether standby or reset cut it short
	always_ff @(posedge clk)
	begin
		on_r <= watchdog_rc_pin_oe ? on_r + 16'h1 : 16'h0;
		kill_r <= standby_enter || core_reset || rst || (kill_r && watchdog_rc_pin_oe);
	end
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no stall on new request");
	a_wait_done: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("stall too long");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("stall while idle");
	a_fixed_outs: assert property (sp_init == 16'h0000 && ext_interrupt_zero_vector == 16'h0003 && !watchdog_rc_pin_o)
		else $error("fixed output wrong");
	a_rst_hold: assert property ($fell(rst) |-> (core_reset && clk_sel_medium_rc)[*8])
		else $error("core reset not held");
	a_rst_nodis: assert property ($fell(rst) |-> !watchdog_rc_pin_oe)
		else $error("discharge on after reset");
	a_pc_pulse: assert property (pc_load |=> !pc_load)
		else $error("pc load not a pulse");
	a_int_pulse: assert property (ext_interrupt_zero |=> !ext_interrupt_zero)
		else $error("interrupt not a pulse");
	a_stretch_len: assert property ($fell(watchdog_rc_pin_oe) && !kill_r |-> on_r >= 16'h0780)
		else $error("discharge too short");
	cover property (pc_load);
	cover property (ext_interrupt_zero);
	cover property ($fell(watchdog_rc_pin_oe));
endmodule

// file: rrwdr_rc_model.sv
`timescale 1ns/1ps
module rrwdr_rc_model #(
	parameter int TAU = 1000
)(
	input wire logic clk, // clock
	input wire logic oe, // transistor on
	input wire logic fast, // double charge rate
	output logic pin // node level
);
	int v_r = 0;
	// Capacitor charges through the resistor unless the transistor sinks it
	always @(posedge clk)
	begin
		if (oe)
			v_r <= 0;
		else if (v_r < TAU)
			v_r <= v_r + (fast ? 2 : 1);
	end
	assign pin = !oe && v_r >= TAU;
endmodule

// file: rc_runaway_watchdog_reset_tb_top.sv
`timescale 1ns/1ps
module rc_runaway_watchdog_reset_tb_top;
	localparam logic [17:0] CA = rrwdr_pkg::CTRL_ADDR;
	logic clk, rst = 1, rd = 0, wr = 0, rn = 1, por = 0, itr = 0, sb = 0, fast = 0, os = 1;
	logic pin, oe, cr, ck, pl, irq, wq;
	logic [17:0] ad = 18'h0;
	logic [31:0] wd = 32'h0, rdat;
	logic [15:0] pa;
	logic [7:0] v, d;
	int n_fail = 0, tests_run = 0, seed = 32'h5019, k;
	rrwdr_top #(.START_ADDR_A(16'h0a00), .START_ADDR_B(16'h0c40)) i_rrwdr_top (.clk(clk), .rst(rst),
		.avs_address(ad), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1),
		.avs_readdata(rdat), .avs_waitrequest(wq), .external_reset_pin_n(rn), .por_lvd_reset(por),
		.itimer_wdt_reset(itr), .standby_enter(sb), .start_opt_sel(os), .watchdog_rc_pin_i(pin),
		.watchdog_rc_pin_o(), .watchdog_rc_pin_oe(oe),
		.core_reset(cr), .clk_sel_medium_rc(ck), .pc_load(pl), .pc_load_addr(pa), .sp_init(),
		.ext_interrupt_zero(irq), .ext_interrupt_zero_vector());
	rrwdr_rc_model i_rrwdr_rc_model (.clk(clk), .oe(oe), .fast(fast), .pin(pin));
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task test_done;
	begin
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] e);
	begin
		tests_run++;
		if (g !== e)
		begin
			$display("ERROR %0t got %h exp %h", $time, g, e);
			n_fail++;
		end
	end
	endtask
	function automatic logic sg(int s);
		return s == 0 ? pl : s == 1 ? irq : s == 2 ? !cr : s == 3 ? !oe : cr;
	endfunction
	// Waits for a condition, sampled between edges
	task automatic wt(int s, int lim);
		int i;
	begin
		for (i = 0; i < lim; i++)
		begin
			@(negedge clk);
			if (sg(s) === 1'b1)
				break;
		end
		if (i == lim)
			n_fail++;
		if (i == lim)
			test_done();
		k = i;
		@(posedge clk);
	end
	endtask
	task automatic bus(logic w, logic [17:0] a, logic [7:0] dt);
		int i;
	begin
		ad <= a;
		wd <= {24'h0, dt};
		wr <= w;
		rd <= !w;
		// Hold the request until an edge samples waitrequest low
		for (i = 0; i < 9; i++)
		begin
			@(posedge clk);
			if (wq === 1'b0)
				break;
		end
		if (i == 9)
			n_fail++;
		if (i == 9)
			test_done();
		v = rdat[7:0];
		wr <= 0;
		rd <= 0;
		@(posedge clk);
	end
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk(cr, 1);
		chk(ck, 1);
		wt(0, 40);
		chk(pa, 16'h0c40);
		bus(1, rrwdr_pkg::CLKS_ADDR, 8'h01);
		chk(ck, 0);
		bus(0, CA, 0);
		chk(v, 0);
		repeat (4)
		begin
			d = 8'($random(seed)) & 8'hb6;
			bus(1, CA, d);
			bus(0, CA, 0);
			chk(v, d & 8'h36);
		end
		bus(1, 18'h00100, 8'hff);
		bus(0, 18'h00100, 0);
		chk(v, 0);
		bus(1, CA, 0);
		wt(3, 2100);
		bus(1, CA, 8'h04);
		@(negedge clk);
		chk(oe, 1);
		repeat (4) @(posedge clk);
		bus(0, rrwdr_pkg::STAT_ADDR, 0);
		chk(v[1:0], 2'b10);
		bus(1, CA, 8'h05);
		bus(1, CA, 8'h20);
		bus(1, CA, 8'h00);
		bus(0, CA, 0);
		chk(v, 8'h05);
		wt(3, 2100);
		bus(1, CA, rrwdr_pkg::CLEAR_CODE);
		wt(3, 2200);
		chk(k >= 1920 && k <= 2048, 1);
		fast <= 1;
		wt(1, 1500);
		chk(cr, 0);
		sb <= 1;
		@(posedge clk);
		sb <= 0;
		bus(0, CA, 0);
		chk(v, 8'h05);
		itr <= 1;
		@(posedge clk);
		itr <= 0;
		wt(4, 9);
		chk(ck, 1);
		wt(2, 60);
		bus(0, CA, 0);
		chk(v, 0);
		bus(1, CA, 8'h01);
		bus(1, CA, 8'h55);
		chk(oe, 0);
		rn <= 0;
		os <= 0;
		repeat (20000) @(posedge clk);
		chk(cr, 1);
		rn <= 1;
		wt(2, 60);
		chk(pa, 16'h0a00);
		bus(0, CA, 0);
		chk(v, 0);
		bus(1, CA, 8'h02);
		wt(4, 20);
		wt(2, 60);
		bus(0, CA, 0);
		chk(v, 8'h80);
		chk(pa, 16'h0a00);
		bus(1, CA, 8'h00);
		bus(0, CA, 0);
		chk(v, 0);
		bus(1, CA, 8'h15);
		sb <= 1;
		@(posedge clk);
		sb <= 0;
		bus(0, CA, 0);
		chk(v, 8'h10);
		chk(oe, 0);
		por <= 1;
		repeat (6) @(posedge clk);
		por <= 0;
		wt(2, 60);
		bus(0, CA, 0);
		chk(v, 0);
		test_done();
	end
endmodule
bind rrwdr_top rrwdr_chk i_rrwdr_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .standby_enter,
	.watchdog_rc_pin_o, .watchdog_rc_pin_oe, .core_reset, .clk_sel_medium_rc, .pc_load, .ext_interrupt_zero,
	.sp_init, .ext_interrupt_zero_vector);
